// ---- tcu_pkg.sv ----
package tcu_pkg;

  // Register byte addresses (word aligned)
  localparam logic [7:0] ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] ADDR_COUNT    = 8'h08;
  localparam logic [7:0] ADDR_CMP_A    = 8'h0c;
  localparam logic [7:0] ADDR_CMP_B    = 8'h10;
  localparam logic [7:0] ADDR_FLAGS    = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_SERVICE  = 8'h1c;

  // timer_control_a fields
  localparam int ACT_A_HI = 7;
  localparam int ACT_A_LO = 6;
  localparam int ACT_B_HI = 5;
  localparam int ACT_B_LO = 4;
  localparam int WM_BIT1  = 1;
  localparam int WM_BIT0  = 0;
  // timer_control_b fields
  localparam int FORCE_A  = 7;
  localparam int FORCE_B  = 6;
  localparam int WM_BIT2  = 3;
  localparam int TSS_HI   = 2;
  localparam int TSS_LO   = 0;
  // timer_flag_reg / timer_irq_mask fields
  localparam int FLG_B    = 2;
  localparam int FLG_A    = 1;
  localparam int FLG_OVF  = 0;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] TSS_NONE   = 3'h0;
  localparam logic [2:0] TSS_DIRECT = 3'h1;
  localparam logic [2:0] TSS_D8     = 3'h2;
  localparam logic [2:0] TSS_D64    = 3'h3;
  localparam logic [2:0] TSS_D256   = 3'h4;
  localparam logic [2:0] TSS_D1024  = 3'h5;
  localparam logic [2:0] TSS_FALL   = 3'h6;
  localparam int PRE_W = 10;

  typedef enum logic [2:0] {
    WM_NORMAL = 3'b000,
    WM_PC_MAX = 3'b001,
    WM_CTC    = 3'b010,
    WM_FP_MAX = 3'b011,
    WM_RSV4   = 3'b100,
    WM_PC_CMP = 3'b101,
    WM_RSV6   = 3'b110,
    WM_FP_CMP = 3'b111
  } tcu_wave_mode_t;

  // Per-channel compare output state
  typedef struct packed {
    logic out_a;
    logic out_b;
  } tcu_cmp_out_t;

endpackage

// ---- tcu_timer.sv ----
`timescale 1ns/1ps
// Function
// RQ1: Counter at zero raises the internal bottom indication.
// RQ2: Counter at all ones (255) is the maximum.
// RQ3: Top is 255 or compare value A, chosen by wave mode.
// RQ4: Three-bit tick source select; zero halts the counter.
// RQ5: Each tick clears, increments or decrements per mode.
// RQ6: CPU may read and write the counter at any time.
// RQ7: CPU counter write beats clear or count in same cycle.
// RQ8: Wave mode: two low bits in control A, high bit in B.
// RQ9: Overflow flag set where the mode says; may request interrupt.
// RQ10: Continuous compare of counter with both compare values.
// RQ11: Compare flag set on the tick after the match.
// RQ12: Enabled flag requests interrupt; cleared by service or write one.
// RQ13: PWM modes double-buffer compare, loaded at top or bottom.
// RQ14: Buffered: CPU hits buffer; unbuffered: active register.
// RQ15: Force strobe acts like a match, no flag, no counter change.
// RQ16: Counter write blocks matches on the next tick, even halted.
// RQ17: Software avoids writing counter equal to compare or zero down.
// RQ18: Output action field changes apply at once, unbuffered.
// RQ19: Compare outputs reset to zero, kept across mode changes.
// RQ20: Nonzero action field overrides port value on the pin.
// RQ21: Direction bit controls pin; output seen only when set.
// RQ22: Compare output can be set up before pin is enabled.
// RQ23: Action field zero means no output action at a match.
// RQ24: Mode 0 normal, 2 clear-on-match A, 3 or 7 fast PWM.
// RQ25: Reserved action settings leave the output unchanged.
module tcu_timer
  import tcu_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // External tick pin
  input  wire logic        ext_tick_pin,
  // Port pins shared with the compare outputs
  input  wire logic        port_val_a,
  input  wire logic        port_val_b,
  input  wire logic        pin_direction_bit_a,
  input  wire logic        pin_direction_bit_b,
  output logic             pin_out_a,
  output logic             pin_oe_a,
  output logic             pin_out_b,
  output logic             pin_oe_b,
  // Interrupt requests, one per flag
  output logic             irq_overflow,
  output logic             irq_match_a,
  output logic             irq_match_b
);

  // Register state
  logic [7:0]     timer_control_a, next_timer_control_a;
  logic [7:0]     timer_control_b, next_timer_control_b;
  logic [7:0]     count_value, next_count_value;
  logic [7:0]     compare_value_a, next_compare_value_a;
  logic [7:0]     compare_value_b, next_compare_value_b;
  logic [7:0]     cmp_buf_a, next_cmp_buf_a;
  logic [7:0]     cmp_buf_b, next_cmp_buf_b;
  logic [2:0]     timer_flag_reg, next_timer_flag_reg;
  logic [2:0]     timer_irq_mask, next_timer_irq_mask;
  tcu_cmp_out_t   cmp_out, next_cmp_out;
  logic           block_match, next_block_match;
  logic [1:0]     pend_match, next_pend_match;
  logic [PRE_W-1:0] prescale, next_prescale;
  logic [2:0]     ext_sync, next_ext_sync;
  logic [31:0]    rdata, next_rdata;

  // Decoded controls
  tcu_wave_mode_t wave_mode_field;
  logic [2:0]     tick_source_select;
  logic [1:0]     act_a, act_b;
  logic           is_pwm, is_fast, is_pc, top_is_a, buffered;
  logic           timer_tick, at_bottom, at_max, at_top;
  logic [7:0]     top_value;
  logic [1:0]     match_raw, match_live;
  logic           wr_en, rd_en, wr_count, wr_flags, wr_service;
  logic           count_down, next_count_down;

  // One-bit output action at a match; reserved settings keep the level
  function automatic logic act_level(input logic [1:0] act,
                                     input logic cur,
                                     input logic pwm,
                                     input logic toggle_ok);
    logic r;
    r = cur;
    case (act)
      2'b00: r = cur; // RQ23
      2'b01: r = (pwm && !toggle_ok) ? cur : ~cur; // RQ25
      2'b10: r = 1'b0;
      2'b11: r = 1'b1;
      default: r = cur;
    endcase
    return r;
  endfunction

  // Level set at bottom for fast PWM waveforms
  function automatic logic bottom_level(input logic [1:0] act,
                                        input logic cur);
    logic r;
    r = cur;
    if (act == 2'b10) begin
      r = 1'b1;
    end else if (act == 2'b11) begin
      r = 1'b0;
    end
    return r;
  endfunction

  assign wave_mode_field = tcu_wave_mode_t'({timer_control_b[WM_BIT2],
    timer_control_a[WM_BIT1], timer_control_a[WM_BIT0]}); // RQ8
  assign tick_source_select = timer_control_b[TSS_HI:TSS_LO];
  assign act_a = timer_control_a[ACT_A_HI:ACT_A_LO]; // RQ18
  assign act_b = timer_control_a[ACT_B_HI:ACT_B_LO]; // RQ18

  assign is_fast  = (wave_mode_field == WM_FP_MAX)
                 || (wave_mode_field == WM_FP_CMP); // RQ24
  assign is_pc    = (wave_mode_field == WM_PC_MAX)
                 || (wave_mode_field == WM_PC_CMP);
  assign is_pwm   = is_fast || is_pc;
  assign buffered = is_pwm; // RQ13
  assign top_is_a = (wave_mode_field == WM_CTC)
                 || (wave_mode_field == WM_FP_CMP)
                 || (wave_mode_field == WM_PC_CMP);
  assign top_value = top_is_a ? compare_value_a : CNT_MAX; // RQ3
  assign at_bottom = (count_value == CNT_BOTTOM); // RQ1
  assign at_max    = (count_value == CNT_MAX); // RQ2
  assign at_top    = (count_value == top_value); // RQ3

  // Comparator runs continuously
  assign match_raw = {count_value == compare_value_b,
                      count_value == compare_value_a}; // RQ10
  assign match_live = block_match ? 2'b00 : match_raw; // RQ16

  // Tick selection: prescaler taps or edges of the synchronised pin
  always_comb begin
    case (tick_source_select)
      TSS_NONE:   timer_tick = 1'b0; // RQ4
      TSS_DIRECT: timer_tick = 1'b1;
      TSS_D8:     timer_tick = (prescale[2:0] == '1);
      TSS_D64:    timer_tick = (prescale[5:0] == '1);
      TSS_D256:   timer_tick = (prescale[7:0] == '1);
      TSS_D1024:  timer_tick = (prescale == '1);
      TSS_FALL:   timer_tick = ext_sync[2] && !ext_sync[1];
      default:    timer_tick = !ext_sync[2] && ext_sync[1];
    endcase
  end

  // APB decode; zero wait states
  assign wr_en      = psel && penable && pwrite;
  assign rd_en      = psel && !penable && !pwrite;
  assign wr_count   = wr_en && (paddr == ADDR_COUNT);
  assign wr_flags   = wr_en && (paddr == ADDR_FLAGS);
  assign wr_service = wr_en && (paddr == ADDR_SERVICE);
  assign pready     = 1'b1;
  assign pslverr    = 1'b0;
  assign prdata     = rdata;

  always_comb begin
    next_rdata = '0;
    if (rd_en) begin
      case (paddr)
        ADDR_CTRL_A:   next_rdata = {24'h0, timer_control_a};
        ADDR_CTRL_B:   next_rdata = {24'h0, timer_control_b[7:6] & 2'b00,
                                     timer_control_b[5:0]};
        ADDR_COUNT:    next_rdata = {24'h0, count_value}; // RQ6
        ADDR_CMP_A:    next_rdata = {24'h0,
                         buffered ? cmp_buf_a : compare_value_a}; // RQ14
        ADDR_CMP_B:    next_rdata = {24'h0,
                         buffered ? cmp_buf_b : compare_value_b}; // RQ14
        ADDR_FLAGS:    next_rdata = {29'h0, timer_flag_reg};
        ADDR_IRQ_MASK: next_rdata = {29'h0, timer_irq_mask};
        default:       next_rdata = '0;
      endcase
    end
  end

  // Counter, compare, flags and outputs
  always_comb begin
    next_timer_control_a = timer_control_a;
    next_timer_control_b = timer_control_b;
    next_count_value     = count_value;
    next_count_down      = count_down;
    next_compare_value_a = compare_value_a;
    next_compare_value_b = compare_value_b;
    next_cmp_buf_a       = cmp_buf_a;
    next_cmp_buf_b       = cmp_buf_b;
    next_timer_flag_reg  = timer_flag_reg;
    next_timer_irq_mask  = timer_irq_mask;
    next_cmp_out         = cmp_out; // RQ19
    next_block_match     = block_match;
    next_pend_match      = pend_match;
    next_prescale        = prescale + 1'b1;
    next_ext_sync        = {ext_sync[1:0], ext_tick_pin};

    // Force strobes read back as zero; they act only in non-PWM modes
    next_timer_control_b[FORCE_A] = 1'b0;
    next_timer_control_b[FORCE_B] = 1'b0;

    // Flag clear by write-one or service; hardware set is applied after
    if (wr_flags) begin
      next_timer_flag_reg = timer_flag_reg & ~pwdata[2:0]; // RQ12
    end
    if (wr_service) begin
      next_timer_flag_reg = next_timer_flag_reg & ~pwdata[2:0]; // RQ12
    end

    if (timer_tick) begin
      // Flag follows the match seen in the previous tick
      next_timer_flag_reg[FLG_A] = next_timer_flag_reg[FLG_A]
                                 | pend_match[0]; // RQ11
      next_timer_flag_reg[FLG_B] = next_timer_flag_reg[FLG_B]
                                 | pend_match[1]; // RQ11
      next_pend_match  = match_live;
      next_block_match = 1'b0;
      // Output waveform at a match
      if (match_live[0]) begin
        next_cmp_out.out_a = act_level(act_a, cmp_out.out_a, is_pwm,
                                       wave_mode_field[2]);
      end
      if (match_live[1]) begin
        next_cmp_out.out_b = act_level(act_b, cmp_out.out_b, is_pwm,
                                       1'b0);
      end
      // Counting sequence
      if (is_pc) begin
        if (at_top) begin
          next_count_down = 1'b1;
        end else if (at_bottom) begin
          next_count_down = 1'b0;
          next_timer_flag_reg[FLG_OVF] = 1'b1; // RQ9
        end
        next_count_value = (at_top || (count_down && !at_bottom))
                         ? count_value - 1'b1 : count_value + 1'b1; // RQ5
        if (at_top) begin
          next_compare_value_a = cmp_buf_a; // RQ13
          next_compare_value_b = cmp_buf_b; // RQ13
        end
      end else if ((top_is_a && at_top) || is_fast && at_top) begin
        next_count_value = CNT_BOTTOM; // RQ5
        next_count_down  = 1'b0;
        if (is_fast) begin
          next_timer_flag_reg[FLG_OVF] = 1'b1; // RQ9
          next_compare_value_a = cmp_buf_a; // RQ13
          next_compare_value_b = cmp_buf_b; // RQ13
          next_cmp_out.out_a = bottom_level(act_a, next_cmp_out.out_a);
          next_cmp_out.out_b = bottom_level(act_b, next_cmp_out.out_b);
        end
      end else begin
        next_count_value = count_value + 1'b1; // RQ5
        next_count_down  = 1'b0;
        if (at_max) begin
          next_timer_flag_reg[FLG_OVF] = 1'b1; // RQ9
        end
      end
    end

    // Register writes
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL_A: next_timer_control_a = pwdata[7:0];
        ADDR_CTRL_B: begin
          next_timer_control_b = pwdata[7:0];
          next_timer_control_b[FORCE_A] = 1'b0;
          next_timer_control_b[FORCE_B] = 1'b0;
          if (!is_pwm && pwdata[FORCE_A]) begin
            next_cmp_out.out_a = act_level(act_a, cmp_out.out_a,
                                           1'b0, 1'b1); // RQ15 RQ22
          end
          if (!is_pwm && pwdata[FORCE_B]) begin
            next_cmp_out.out_b = act_level(act_b, cmp_out.out_b,
                                           1'b0, 1'b1); // RQ15 RQ22
          end
        end
        ADDR_COUNT: begin
          next_count_value = pwdata[7:0]; // RQ7
          next_block_match = 1'b1; // RQ16
        end
        ADDR_CMP_A: begin
          next_cmp_buf_a = pwdata[7:0]; // RQ14
          if (!buffered) begin
            next_compare_value_a = pwdata[7:0]; // RQ14
          end
        end
        ADDR_CMP_B: begin
          next_cmp_buf_b = pwdata[7:0]; // RQ14
          if (!buffered) begin
            next_compare_value_b = pwdata[7:0]; // RQ14
          end
        end
        ADDR_IRQ_MASK: next_timer_irq_mask = pwdata[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_a <= RST_BYTE;
      timer_control_b <= RST_BYTE;
      count_value     <= RST_BYTE;
      count_down      <= 1'b0;
      compare_value_a <= RST_BYTE;
      compare_value_b <= RST_BYTE;
      cmp_buf_a       <= RST_BYTE;
      cmp_buf_b       <= RST_BYTE;
      timer_flag_reg  <= '0;
      timer_irq_mask  <= '0;
      cmp_out         <= '0; // RQ19
      block_match     <= 1'b0;
      pend_match      <= 2'b00;
      prescale        <= '0;
      ext_sync        <= '0;
      rdata           <= '0;
    end else if (clk_en) begin
      timer_control_a <= next_timer_control_a;
      timer_control_b <= next_timer_control_b;
      count_value     <= next_count_value;
      count_down      <= next_count_down;
      compare_value_a <= next_compare_value_a;
      compare_value_b <= next_compare_value_b;
      cmp_buf_a       <= next_cmp_buf_a;
      cmp_buf_b       <= next_cmp_buf_b;
      timer_flag_reg  <= next_timer_flag_reg;
      timer_irq_mask  <= next_timer_irq_mask;
      cmp_out         <= next_cmp_out;
      block_match     <= next_block_match;
      pend_match      <= next_pend_match;
      prescale        <= next_prescale;
      ext_sync        <= next_ext_sync;
      rdata           <= next_rdata;
    end
  end

  // Interrupt requests
  assign irq_overflow = timer_flag_reg[FLG_OVF] & timer_irq_mask[FLG_OVF];
  assign irq_match_a  = timer_flag_reg[FLG_A] & timer_irq_mask[FLG_A]; // RQ12
  assign irq_match_b  = timer_flag_reg[FLG_B] & timer_irq_mask[FLG_B]; // RQ12

  // Pin override; direction stays with the port
  assign pin_out_a = (act_a != 2'b00) ? cmp_out.out_a : port_val_a; // RQ20
  assign pin_out_b = (act_b != 2'b00) ? cmp_out.out_b : port_val_b; // RQ20
  assign pin_oe_a  = pin_direction_bit_a; // RQ21
  assign pin_oe_b  = pin_direction_bit_b; // RQ21

endmodule

// ---- tcu_timer_asserts.sv ----
`timescale 1ns/1ps
module tcu_timer_asserts
  import tcu_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        clk_en,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        port_val_a,
  input wire logic        port_val_b,
  input wire logic        pin_direction_bit_a,
  input wire logic        pin_direction_bit_b,
  input wire logic        pin_out_a,
  input wire logic        pin_oe_a,
  input wire logic        pin_out_b,
  input wire logic        pin_oe_b,
  input wire logic        irq_match_a
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_oe_dir_a: assert property (pin_oe_a == pin_direction_bit_a)
    else $error("pin a enable does not follow direction");
  a_oe_dir_b: assert property (pin_oe_b == pin_direction_bit_b)
    else $error("pin b enable does not follow direction");
  a_ready_high: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  a_no_err: assert property (psel && penable |-> !pslverr)
    else $error("slave error raised");
  a_idle_rdata: assert property (!(psel && penable) |-> prdata == 32'h0)
    else $error("read data outside access phase");
  a_rd_upper: assert property (psel && penable && !pwrite |->
    prdata[31:8] == 24'h0) else $error("upper read bits set");
  // A cleared action field hands the pin back to the port at once
  a_act_off_a: assert property (psel && penable && pwrite && clk_en &&
    paddr == ADDR_CTRL_A && pwdata[ACT_A_HI:ACT_A_LO] == 2'h0
    |=> pin_out_a == port_val_a) else $error("pin a not released");
  a_act_off_b: assert property (psel && penable && pwrite && clk_en &&
    paddr == ADDR_CTRL_A && pwdata[ACT_B_HI:ACT_B_LO] == 2'h0
    |=> pin_out_b == port_val_b) else $error("pin b not released");
  a_irq_frozen: assert property ($rose(irq_match_a) |-> $past(clk_en))
    else $error("match request rose while frozen");
endmodule

bind tcu_timer tcu_timer_asserts chk (
  .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .port_val_a(port_val_a), .port_val_b(port_val_b),
  .pin_direction_bit_a(pin_direction_bit_a),
  .pin_direction_bit_b(pin_direction_bit_b), .pin_out_a(pin_out_a),
  .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b),
  .irq_match_a(irq_match_a));

// ---- timer8_counter_compare_unit_bench.sv ----
`timescale 1ns/1ps
module timer8_counter_compare_unit_bench;
  import tcu_pkg::*;
  logic        core_clk, rst_n, clk_en, psel, penable, pwrite, ext_tick_pin;
  logic        port_val_a, port_val_b, pin_direction_bit_a, pin_direction_bit_b;
  logic [7:0]  paddr, rd, top, cnt, oc_a, oc_b;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b;
  logic        irq_overflow, irq_match_a, irq_match_b;
  int          errors, tests_run;

  tcu_timer dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_tick_pin(ext_tick_pin), .port_val_a(port_val_a),
    .port_val_b(port_val_b), .pin_direction_bit_a(pin_direction_bit_a),
    .pin_direction_bit_b(pin_direction_bit_b), .pin_out_a(pin_out_a),
    .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b),
    .irq_overflow(irq_overflow), .irq_match_a(irq_match_a),
    .irq_match_b(irq_match_b));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One transfer; an idle cycle always separates two transfers
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      give_verdict();
    end
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check8(rd, exp);
    check8({7'h0, pslverr}, 8'h00);
  endtask

  initial begin
    #(50 * 20000);
    errors++;
    give_verdict();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    rst_n = 1'b0;
    clk_en = 1'b1;
    {psel, penable, pwrite, ext_tick_pin} = 4'h0;
    {port_val_a, port_val_b, pin_direction_bit_a, pin_direction_bit_b} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    oc_a = 8'h00;
    oc_b = 8'h00;
    void'($urandom(69177));
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(8'(i * 4), RST_BYTE);
    rchk(8'h40, 8'h00);
    // Halted counter keeps whatever software wrote
    top = 8'($urandom_range(255, 0));
    wr(ADDR_COUNT, top);
    repeat (5) @(posedge core_clk);
    rchk(ADDR_COUNT, top);
    top = 8'($urandom_range(255, 0));
    wr(ADDR_CMP_B, top);
    rchk(ADDR_CMP_B, top);
    // Short run from the maximum must wrap and flag overflow only
    wr(ADDR_CMP_A, 8'h80);
    // Compare B equals the written count, so only the block keeps flag B low
    wr(ADDR_CMP_B, CNT_MAX);
    wr(ADDR_COUNT, CNT_MAX);
    wr(ADDR_CTRL_B, {5'h0, TSS_DIRECT});
    wr(ADDR_CTRL_B, {5'h0, TSS_NONE});
    rchk(ADDR_FLAGS, 8'h01);
    apb(1'b0, ADDR_COUNT, 8'h00);
    // Three ticks: idle, setup and access edges of the stop write
    check8(rd, 8'(CNT_MAX + 3));
    wr(ADDR_IRQ_MASK, 8'h07);
    @(negedge core_clk);
    check8({7'h0, irq_overflow}, 8'h01);
    wr(ADDR_SERVICE, 8'h01);
    @(negedge core_clk);
    check8({7'h0, irq_overflow}, 8'h00);
    // Clear-on-match: counter never passes a small random top
    top = 8'($urandom_range(9, 2));
    wr(ADDR_COUNT, CNT_BOTTOM);
    wr(ADDR_CMP_A, top);
    wr(ADDR_CTRL_A, 8'h02);
    wr(ADDR_CTRL_B, {5'h0, TSS_DIRECT});
    repeat (40) @(posedge core_clk);
    clk_en <= 1'b0;
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b1;
    wr(ADDR_CTRL_B, {5'h0, TSS_NONE});
    apb(1'b0, ADDR_COUNT, 8'h00);
    cnt = rd;
    // 40 free ticks, none while frozen, three more in the stop write
    check8(cnt, 8'(43 % (top + 1)));
    rchk(ADDR_FLAGS, 8'h02);
    @(negedge core_clk);
    check8({6'h0, irq_match_b, irq_match_a}, 8'h01);
    wr(ADDR_FLAGS, 8'h07);
    rchk(ADDR_FLAGS, 8'h00);
    // Force strobes in normal mode, pin A made an output after the first force
    wr(ADDR_CTRL_A, 8'h00);
    port_val_a <= 1'b1;
    port_val_b <= 1'($urandom_range(1, 0));
    pin_direction_bit_b <= 1'($urandom_range(1, 0));
    @(negedge core_clk);
    check8({7'h0, pin_out_a}, 8'h01);
    wr(ADDR_CTRL_A, 8'h70);
    @(negedge core_clk);
    check8({6'h0, pin_out_a, pin_out_b}, {6'h0, oc_a[0], oc_b[0]});
    check8({7'h0, pin_oe_a}, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CTRL_B, 8'hc0);
      oc_a = ~oc_a;
      oc_b = 8'h01;
      @(negedge core_clk);
      check8({6'h0, pin_out_a, pin_out_b}, {6'h0, oc_a[0], oc_b[0]});
      @(posedge core_clk);
      pin_direction_bit_a <= 1'b1;
    end
    check8({7'h0, pin_oe_a}, 8'h01);
    check8({7'h0, pin_oe_b}, {7'h0, pin_direction_bit_b});
    rchk(ADDR_FLAGS, 8'h00);
    rchk(ADDR_COUNT, cnt);
    wr(ADDR_CTRL_A, 8'h02);
    @(negedge core_clk);
    check8({6'h0, pin_out_a, pin_out_b},
           {6'h0, port_val_a, port_val_b});
    // Fast PWM at maximum top: compare writes reach only the buffer
    top = 8'($urandom_range(254, 2));
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_CMP_B, top);
    rchk(ADDR_CMP_B, top);
    wr(ADDR_CTRL_A, 8'h00);
    rchk(ADDR_CMP_B, CNT_MAX);
    wr(ADDR_CTRL_A, 8'h03);
    wr(ADDR_COUNT, CNT_MAX);
    wr(ADDR_CTRL_B, {5'h0, TSS_DIRECT});
    wr(ADDR_CTRL_B, {5'h0, TSS_NONE});
    rchk(ADDR_COUNT, 8'(CNT_MAX + 3));
    wr(ADDR_CTRL_A, 8'h00);
    rchk(ADDR_CMP_B, top);
    give_verdict();
  end
endmodule
